// ### core/epi_defines.svh
// Constants for the encoder position and index unit
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
`define EPI_PAR_COUNT    8'h00
`define EPI_PAR_ENCTYPE  8'h01
`define EPI_PAR_INDEX    8'h02
`define EPI_PAR_OFFSET   8'h03
`define EPI_PAR_UNUSED   8'h04
`define EPI_PAR_POSITION 8'h10
`define EPI_PAR_STATUS   8'h11
`define EPI_ENC_NONE     8'h00
`define EPI_ENC_QUAD     8'h01
`define EPI_ENC_QUADINV  8'h02
`define EPI_ENC_SSI_MIN  8'h08
`define EPI_ENC_SSI_MAX  8'h1E
`define EPI_IDX_OFF      2'h0
`define EPI_IDX_STOP     2'h1
`define EPI_IDX_ZERO     2'h2
`define EPI_IDX_BOTH     2'h3
`define EPI_RST_ENCTYPE  8'h00
`define EPI_RST_INDEX    2'h0
`define EPI_RST_OFFSET   32'h0000_0000
`define EPI_SSI_HALF_NS  500
`define EPI_CLK_NS       8
`define EPI_SSI_HALF_CYC ((`EPI_SSI_HALF_NS) / (`EPI_CLK_NS))
`define EPI_SSI_GAP_CYC  (4 * `EPI_SSI_HALF_CYC)
`endif

// ### core/epi_pkg.sv
// Types for the encoder position and index unit
package epi_pkg;
    typedef enum logic [1:0] {
        EPI_SSI_IDLE  = 2'h0,
        EPI_SSI_LOW   = 2'h1,
        EPI_SSI_HIGH  = 2'h3,
        EPI_SSI_GAP   = 2'h2
    } epi_ssi_state_t;
endpackage

// ### core/epi_ssi_reader.sv
// Two-wire absolute encoder reader producing one word per frame
`include "epi_defines.svh"
module epi_ssi_reader
    import epi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic [4:0]  wordBits,
    input  wire logic        ssiData,
    output logic             ssiClk,
    output logic [29:0]      word,
    output logic             wordValid
);
    typedef struct packed {
        epi_ssi_state_t state;
        logic [15:0]    timer;
        logic [4:0]     bitCnt;
        logic [29:0]    shift;
        logic [29:0]    word;
        logic           valid;
        logic           clkOut;
    } epi_ssi_regs_t;

    localparam logic [15:0] HALF = 16'(`EPI_SSI_HALF_CYC);
    localparam logic [15:0] GAP  = 16'(`EPI_SSI_GAP_CYC);

    epi_ssi_regs_t r;
    epi_ssi_regs_t next_r;

    // Clock out bits MSB first, latch on rising edge of the encoder clock
    always_comb begin
        next_r = r;
        next_r.valid = 1'b0;
        case (r.state)
            EPI_SSI_IDLE: begin
                next_r.clkOut = 1'b1;
                if (enable) begin
                    next_r.state  = EPI_SSI_LOW;
                    next_r.timer  = HALF;
                    next_r.bitCnt = wordBits;
                    next_r.shift  = '0;
                    next_r.clkOut = 1'b0;
                end
            end
            EPI_SSI_LOW: begin
                if (r.timer > 16'h0001) begin
                    next_r.timer = r.timer - 16'h0001;
                end else begin
                    next_r.state  = EPI_SSI_HIGH;
                    next_r.timer  = HALF;
                    next_r.clkOut = 1'b1;
                    next_r.shift  = {r.shift[28:0], ssiData};
                    next_r.bitCnt = r.bitCnt - 5'h01;
                end
            end
            EPI_SSI_HIGH: begin
                if (r.timer > 16'h0001) begin
                    next_r.timer = r.timer - 16'h0001;
                end else if (r.bitCnt == 5'h00) begin
                    next_r.state = EPI_SSI_GAP;
                    next_r.timer = GAP;
                    next_r.word  = r.shift;
                    next_r.valid = 1'b1;
                end else begin
                    next_r.state  = EPI_SSI_LOW;
                    next_r.timer  = HALF;
                    next_r.clkOut = 1'b0;
                end
            end
            default: begin
                if (r.timer > 16'h0001) begin
                    next_r.timer = r.timer - 16'h0001;
                end else begin
                    next_r.state = EPI_SSI_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{EPI_SSI_IDLE, 16'h0000, 5'h00, 30'h0, 30'h0, 1'b0, 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign ssiClk    = r.clkOut;
    assign word      = r.word;
    assign wordValid = r.valid;
endmodule

// ### core/epi_position_unit.sv
// Encoder position, offset and index unit for one axis
// How it works
// - parameter 0 reads raw count without offset
// - position report returns count plus offset
// - type 0 none, 1 quad, 2 inverted
// - SSI word extended to 32 bits by laps
// - index mark is A, B, Z high
// - index mode off, stop, zero, both
// - index found returns mode to off
// - offset defaults zero, added to count
// - set command per axis or broadcast
//
// Local design decisions: the strobed register port and the register offsets.
`include "epi_defines.svh"
module epi_position_unit
    import epi_pkg::*;
#(
    parameter logic [3:0] AXIS = 4'h1
)(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  cmdAxis,
    input  wire logic [7:0]  cmdPar,
    input  wire logic [31:0] cmdWdata,
    input  wire logic        cmdWr,
    input  wire logic        cmdRd,
    output logic [31:0]      cmdRdata,
    input  wire logic        encA,
    input  wire logic        encB,
    input  wire logic        encZ,
    input  wire logic        ssiData,
    output logic             ssiClk,
    output logic             motorStop,
    output logic             indexFound,
    output logic [31:0]      position
);
    typedef struct packed {
        logic [31:0] count;
        logic [7:0]  encType;
        logic [1:0]  indexMode;
        logic [31:0] offset;
        logic [1:0]  abPrev;
        logic [29:0] ssiPrev;
        logic        ssiPrimed;
        logic [31:0] rdata;
        logic        stop;
        logic        found;
        logic        foundPulse;
    } epi_regs_t;

    epi_regs_t   r;
    epi_regs_t   next_r;
    logic        isQuad;
    logic        isSsi;
    logic [4:0]  ssiBits;
    logic [29:0] ssiWord;
    logic        ssiValid;
    logic [29:0] ssiMask;
    logic [29:0] ssiDelta;
    logic        markSeen;
    logic        hit;
    logic [31:0] posSum;

    // Encoder type decode
    // type selects counting
    assign isQuad  = (r.encType == `EPI_ENC_QUAD) || (r.encType == `EPI_ENC_QUADINV);
    assign isSsi   = (r.encType >= `EPI_ENC_SSI_MIN) && (r.encType <= `EPI_ENC_SSI_MAX);
    // SSI code gives the word width
    assign ssiBits = isSsi ? r.encType[4:0] : 5'h00;
    assign markSeen = encA && encB && encZ;
    assign hit      = markSeen && (r.indexMode != `EPI_IDX_OFF) && isQuad;
    assign posSum   = r.count + r.offset;

    // Absolute encoder front end
    epi_ssi_reader u_ssi (
        .clk       (clk),
        .rst       (rst),
        .enable    (isSsi),
        .wordBits  (ssiBits),
        .ssiData   (ssiData),
        .ssiClk    (ssiClk),
        .word      (ssiWord),
        .wordValid (ssiValid)
    );

    // Width mask and wrapped difference for lap counting
    always_comb begin
        ssiMask  = 30'h0;
        for (int i = 0; i < 30; i++) begin
            ssiMask[i] = (5'(i) < ssiBits);
        end
        ssiDelta = (ssiWord - r.ssiPrev) & ssiMask;
    end

    // Next state
    always_comb begin
        next_r = r;
        next_r.abPrev     = {encA, encB};
        next_r.foundPulse = 1'b0;
        if (isQuad) begin
            case ({r.abPrev, encA, encB})
                4'b0001, 4'b0111, 4'b1110, 4'b1000:
                    next_r.count = (r.encType == `EPI_ENC_QUAD) ? r.count + 32'h1
                                                               : r.count - 32'h1;
                4'b0010, 4'b1011, 4'b1101, 4'b0100:
                    next_r.count = (r.encType == `EPI_ENC_QUAD) ? r.count - 32'h1
                                                               : r.count + 32'h1;
                default: next_r.count = r.count;
            endcase
        end else if (isSsi && ssiValid) begin
            // signed step within half a turn extends laps
            if (!r.ssiPrimed) begin
                next_r.count = {2'b00, ssiWord};
            end else if (ssiDelta[ssiBits - 5'h01]) begin
                next_r.count = r.count - 32'({2'b00, (~ssiDelta + 30'h1) & ssiMask});
            end else begin
                next_r.count = r.count + {2'b00, ssiDelta};
            end
            next_r.ssiPrev   = ssiWord;
            next_r.ssiPrimed = 1'b1;
        end
        if (!isSsi) begin
            next_r.ssiPrimed = 1'b0;
        end
        if (hit) begin
            if (r.indexMode == `EPI_IDX_ZERO || r.indexMode == `EPI_IDX_BOTH) begin
                next_r.count = 32'h0;
            end
            if (r.indexMode == `EPI_IDX_STOP || r.indexMode == `EPI_IDX_BOTH) begin
                next_r.stop = 1'b1;
            end
            next_r.found      = 1'b1;
            next_r.foundPulse = 1'b1;
            next_r.indexMode  = `EPI_IDX_OFF;
        end
        if (cmdWr && (cmdAxis == AXIS || cmdAxis == 4'h0)) begin
            if (cmdPar == `EPI_PAR_ENCTYPE) begin
                next_r.encType = cmdWdata[7:0];
            end else if (cmdPar == `EPI_PAR_INDEX) begin
                next_r.indexMode = cmdWdata[1:0];
                // A hit in the same cycle keeps its flags
                if (!hit) begin
                    next_r.stop  = 1'b0;
                    next_r.found = 1'b0;
                end
            end else if (cmdPar == `EPI_PAR_OFFSET) begin
                next_r.offset = cmdWdata;
            end else if (cmdPar == `EPI_PAR_COUNT) begin
                next_r.count = cmdWdata;
            end
        end
        next_r.rdata = 32'h0;
        if (cmdRd && (cmdAxis == AXIS || cmdAxis == 4'h0)) begin
            if (cmdPar == `EPI_PAR_COUNT) begin
                next_r.rdata = r.count;
            end else if (cmdPar == `EPI_PAR_ENCTYPE) begin
                next_r.rdata = {24'h0, r.encType};
            end else if (cmdPar == `EPI_PAR_INDEX) begin
                next_r.rdata = {30'h0, r.indexMode};
            end else if (cmdPar == `EPI_PAR_OFFSET) begin
                next_r.rdata = r.offset;
            end else if (cmdPar == `EPI_PAR_POSITION) begin
                next_r.rdata = posSum;
            end else if (cmdPar == `EPI_PAR_STATUS) begin
                next_r.rdata = {30'h0, r.found, r.stop};
            end else begin
                next_r.rdata = 32'h0;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{32'h0, `EPI_RST_ENCTYPE, `EPI_RST_INDEX, `EPI_RST_OFFSET,
                   2'b00, 30'h0, 1'b0, 32'h0, 1'b0, 1'b0, 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign cmdRdata   = r.rdata;
    assign motorStop  = r.stop;
    assign indexFound = r.foundPulse;
    assign position   = posSum;

    // Command port read-back checks
    property p_raw_read;
        @(posedge clk) disable iff (rst)
        (cmdRd && cmdAxis == AXIS && cmdPar == `EPI_PAR_COUNT) |=> cmdRdata == $past(r.count);
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw count read wrong");

    property p_pos_read;
        @(posedge clk) disable iff (rst)
        (cmdRd && cmdAxis == AXIS && cmdPar == `EPI_PAR_POSITION)
            |=> cmdRdata == $past(r.count) + $past(r.offset);
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("position read wrong");

    // Counting holds without a live encoder
    property p_none_hold;
        @(posedge clk) disable iff (rst)
        (r.encType == `EPI_ENC_NONE && !cmdWr) |=> r.count == $past(r.count);
    endproperty
    a_none_hold: assert property (p_none_hold) else $error("count moved without encoder");

    property p_reserved_hold;
        @(posedge clk) disable iff (rst)
        (r.encType > `EPI_ENC_QUADINV && r.encType < `EPI_ENC_SSI_MIN && !cmdWr)
            |=> $stable(r.count);
    endproperty
    a_reserved_hold: assert property (p_reserved_hold) else $error("reserved type counted");

    // Index search checks
    sequence s_index_hit;
        hit && !cmdWr;
    endsequence
    property p_index_exit;
        @(posedge clk) disable iff (rst)
        s_index_hit |=> r.indexMode == `EPI_IDX_OFF && indexFound ##1 !indexFound;
    endproperty
    a_index_exit: assert property (p_index_exit) else $error("index mode not left");

    property p_index_zero;
        @(posedge clk) disable iff (rst)
        (hit && !cmdWr && r.indexMode[1]) |=> r.count == 32'h0;
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("index zero failed");

    property p_mark;
        @(posedge clk) disable iff (rst)
        (r.indexMode != `EPI_IDX_OFF && isQuad && !(encA && encB && encZ) && !cmdWr)
            |=> !indexFound && r.indexMode == $past(r.indexMode);
    endproperty
    a_mark: assert property (p_mark) else $error("index without mark");

    // Parameter access checks
    property p_offset;
        @(posedge clk) disable iff (rst)
        (cmdWr && (cmdAxis == AXIS || cmdAxis == 4'h0) && cmdPar == `EPI_PAR_OFFSET)
            |=> position == r.count + $past(cmdWdata);
    endproperty
    a_offset: assert property (p_offset) else $error("offset not added");

    property p_unused;
        @(posedge clk) disable iff (rst)
        (cmdRd && cmdPar == `EPI_PAR_UNUSED) |=> cmdRdata == 32'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused parameter nonzero");

    property p_other_axis;
        @(posedge clk) disable iff (rst)
        (cmdWr && cmdAxis != AXIS && cmdAxis != 4'h0 && cmdPar == `EPI_PAR_OFFSET)
            |=> $stable(r.offset);
    endproperty
    a_other_axis: assert property (p_other_axis) else $error("foreign axis write taken");

    // Counting direction per encoder type
    sequence s_quad_fwd;
        r.encType == `EPI_ENC_QUAD && r.abPrev == 2'b01 && encA && encB && !hit && !cmdWr;
    endsequence
    property p_quad_fwd;
        @(posedge clk) disable iff (rst)
        s_quad_fwd |=> r.count == $past(r.count) + 32'h1;
    endproperty
    a_quad_fwd: assert property (p_quad_fwd) else $error("forward step wrong");

    sequence s_quad_inv;
        r.encType == `EPI_ENC_QUADINV && r.abPrev == 2'b11 && encA && !encB && !hit && !cmdWr;
    endsequence
    property p_quad_inv;
        @(posedge clk) disable iff (rst)
        s_quad_inv |=> r.count == $past(r.count) - 32'h1;
    endproperty
    a_quad_inv: assert property (p_quad_inv) else $error("inverted step wrong");

    // Stop request follows a hit in modes one and three
    property p_index_stop;
        @(posedge clk) disable iff (rst)
        (hit && !cmdWr && r.indexMode[0]) |=> motorStop;
    endproperty
    a_index_stop: assert property (p_index_stop) else $error("index stop missing");

    // Writing the index mode releases the stop request
    property p_stop_clear;
        @(posedge clk) disable iff (rst)
        (cmdWr && (cmdAxis == AXIS || cmdAxis == 4'h0) && cmdPar == `EPI_PAR_INDEX && !hit)
            |=> !motorStop;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stop not released");

    // First absolute word loads the count as it stands
    property p_ssi_first;
        @(posedge clk) disable iff (rst)
        (isSsi && ssiValid && !r.ssiPrimed && !cmdWr) |=> r.count == {2'b00, $past(ssiWord)};
    endproperty
    a_ssi_first: assert property (p_ssi_first) else $error("first word not loaded");
endmodule

// ### verification/epi_enc_model.sv
// Behavioural quadrature and two-wire absolute encoder on the far side
module epi_enc_model (
    input  wire logic ssiClk,
    input  wire logic clk,
    output logic      encA,
    output logic      encB,
    output logic      encZ,
    output logic      ssiData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase;
    logic [29:0] ssiWord;
    logic [29:0] frameWord;
    logic [4:0]  ssiBits;
    logic [4:0]  bitIdx;
    logic [7:0]  highCnt;
    logic        lastClk;
    logic        lastBit;

    // Power-up state of the scale and the line
    initial begin
        phase = 2'h0;
        encZ = 1'b0;
        ssiWord = 30'h0;
        frameWord = 30'h0;
        ssiBits = 5'h08;
        bitIdx = 5'h07;
        highCnt = 8'h00;
        lastClk = 1'b1;
        lastBit = 1'b1;
        ssiData = 1'b0;
    end

    // Gray order 00, 01, 11, 10 as {A, B} for forward motion
    assign encA = phase[1];
    assign encB = phase[1] ^ phase[0];

    task automatic step(input bit up, input int slow);
        @(posedge clk);
        phase <= up ? phase + 2'h1 : phase - 2'h1;
        repeat (3 + slow) @(posedge clk);
    endtask

    // Index track level
    task automatic setZ(input bit z);
        @(posedge clk);
        encZ <= z;
    endtask

    // Word goes out MSB first, a new bit at each falling clock
    always @(posedge clk) begin
        lastClk <= ssiClk;
        highCnt <= ssiClk ? (highCnt == 8'hFF ? highCnt : highCnt + 8'h01) : 8'h00;
        if (lastClk && !ssiClk) begin
            ssiData <= (bitIdx < ssiBits) ? frameWord[bitIdx] : lastBit;
            lastBit <= (bitIdx < ssiBits) ? frameWord[bitIdx] : lastBit;
            bitIdx <= bitIdx - 5'h01;
        end else if (highCnt > 8'h50) begin
            // Released between frames: never leave the last bit standing
            ssiData <= !lastBit;
            bitIdx <= ssiBits - 5'h01;
            frameWord <= ssiWord; // A move between frames never tears a word
        end
    end
endmodule

// ### verification/epi_position_unit_bench.sv
// Self-checking bench for the encoder position and index unit
`include "epi_defines.svh"
module epi_position_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst;
    logic [3:0]  cmdAxis;
    logic [7:0]  cmdPar;
    logic [31:0] cmdWdata;
    logic        cmdWr;
    logic        cmdRd;
    logic [31:0] cmdRdata;
    logic        encA;
    logic        encB;
    logic        encZ;
    logic        ssiData;
    logic        ssiClk;
    logic        motorStop;
    logic        indexFound;
    logic [31:0] position;
    int          nFail;
    int          checkCount;
    int          nFound;
    int          cycles;
    int          seen;

    epi_position_unit DUT (.clk(clk), .rst(rst), .cmdAxis(cmdAxis), .cmdPar(cmdPar),
        .cmdWdata(cmdWdata), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata),
        .encA(encA), .encB(encB), .encZ(encZ), .ssiData(ssiData), .ssiClk(ssiClk),
        .motorStop(motorStop), .indexFound(indexFound), .position(position));
    epi_enc_model enc (.ssiClk(ssiClk), .clk(clk), .encA(encA), .encB(encB),
        .encZ(encZ), .ssiData(ssiData));

    // Clock at 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] ax, input logic [7:0] par, input logic [31:0] val);
        @(posedge clk);
        cmdAxis <= ax;
        cmdPar <= par;
        cmdWdata <= val;
        cmdWr <= 1'b1;
        @(posedge clk);
        cmdWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic expectPar(input string name, input logic [7:0] par, input logic [31:0] exp);
        @(posedge clk);
        cmdAxis <= 4'h1;
        cmdPar <= par;
        cmdRd <= 1'b1;
        @(posedge clk);
        cmdRd <= 1'b0;
        #1;
        check(name, exp, cmdRdata);
    endtask

    task automatic finalReport;
        $display("Checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Index pulses and hang guard
    always @(posedge clk) begin
        if (indexFound === 1'b1) begin
            nFound++;
        end
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            finalReport();
        end
    end

    initial begin
        rst = 1'b1;
        cmdAxis = 4'h1;
        cmdPar = 8'h00;
        cmdWdata = 32'h0;
        cmdWr = 1'b0;
        cmdRd = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        expectPar("type reset", `EPI_PAR_ENCTYPE, 32'h0);
        expectPar("index reset", `EPI_PAR_INDEX, 32'h0);
        expectPar("offset reset", `EPI_PAR_OFFSET, 32'h0);
        $display("Test defaults done");
        wr(4'h1, `EPI_PAR_ENCTYPE, 32'h1);
        repeat (5) enc.step(1'b1, 0);
        wr(4'h1, `EPI_PAR_OFFSET, 32'h0000_0100);
        expectPar("raw count", `EPI_PAR_COUNT, 32'h5);
        expectPar("position report", `EPI_PAR_POSITION, 32'h0000_0105);
        check("position port", 32'h0000_0105, position);
        wr(4'h1, `EPI_PAR_ENCTYPE, 32'h2);
        repeat (3) enc.step(1'b1, 1);
        expectPar("inverted count", `EPI_PAR_COUNT, 32'h2);
        $display("Test quadrature done");
        // Reserved types hold the count
        for (int t = 3; t <= 7; t++) begin
            wr(4'h1, `EPI_PAR_ENCTYPE, 32'(t));
            enc.step(1'b1, 0);
            expectPar("reserved count", `EPI_PAR_COUNT, 32'h2);
        end
        wr(4'h1, `EPI_PAR_UNUSED, 32'h0000_0055);
        expectPar("unused param", `EPI_PAR_UNUSED, 32'h0);
        expectPar("unknown param", 8'h20, 32'h0);
        wr(4'h2, `EPI_PAR_OFFSET, 32'h0000_0007);
        expectPar("other axis", `EPI_PAR_OFFSET, 32'h0000_0100);
        wr(4'h0, `EPI_PAR_OFFSET, 32'h0000_0200);
        expectPar("broadcast", `EPI_PAR_OFFSET, 32'h0000_0200);
        $display("Test access done");
        // Phase is 01 here; the next forward step reaches the mark
        wr(4'h1, `EPI_PAR_ENCTYPE, 32'h1);
        for (int m = 1; m <= 3; m++) begin
            wr(4'h1, `EPI_PAR_COUNT, 32'h0000_000A);
            wr(4'h1, `EPI_PAR_INDEX, 32'(m));
            enc.setZ(1'b1);
            expectPar("armed", `EPI_PAR_INDEX, 32'(m));
            seen = nFound;
            enc.step(1'b1, 0);
            check("found pulse", 32'(seen + 1), 32'(nFound));
            expectPar("mode after hit", `EPI_PAR_INDEX, 32'h0);
            expectPar("count after hit", `EPI_PAR_COUNT, m == 1 ? 32'hB : 32'h0);
            check("motor stop", {31'h0, m != 2}, {31'h0, motorStop});
            enc.setZ(1'b0);
            enc.step(1'b0, m);
        end
        $display("Test index done");
        enc.ssiWord = 30'h0000_00FF;
        wr(4'h1, `EPI_PAR_ENCTYPE, 32'h0000_0008);
        repeat (4000) @(posedge clk);
        expectPar("first word", `EPI_PAR_COUNT, 32'h0000_00FF);
        enc.ssiWord = 30'h0;
        repeat (4000) @(posedge clk);
        expectPar("lap count", `EPI_PAR_COUNT, 32'h0000_0100);
        check("position port", 32'h0000_0300, position);
        $display("Test absolute done");
        finalReport();
    end
endmodule
